// File: design/ulk_map.svh
/*
  register offsets, field positions, port numbers and reset values of the
  legacy keyboard emulation block.
  assumes byte offsets relative to the operational register base.
*/
`ifndef ULK_MAP_SVH
`define ULK_MAP_SVH

// operational register offsets
`define ULK_OFF_CONTROL 12'h100
`define ULK_OFF_INPUT   12'h104
`define ULK_OFF_OUTPUT  12'h108
`define ULK_OFF_STATUS  12'h10c

// legacy i/o ports
`define ULK_PORT_DATA   16'h0060
`define ULK_PORT_CMD    16'h0064
`define ULK_GATE_CMD    8'hd1

// control field positions
`define ULK_CTL_EE      0
`define ULK_CTL_EI      1
`define ULK_CTL_CP      2
`define ULK_CTL_LEGACY_IRQ_ENABLE   3
`define ULK_CTL_EXTERNAL_IRQ_ENABLE  4
`define ULK_CTL_GSEQ    5
`define ULK_CTL_KBDA    6
`define ULK_CTL_MSEA    7
`define ULK_CTL_A20     8

// status field positions
`define ULK_ST_OUT_FULL 0
`define ULK_ST_IN_FULL  1
`define ULK_ST_CMD_DATA 3
`define ULK_ST_AUX_FULL 5

// data bit compared against the gate state
`define ULK_GATE_BIT    1

// reset values
`define ULK_CTRL_RST    9'h000
`define ULK_BYTE_RST    8'h00

`endif

// File: design/ulk_pkg.sv
/*
  types of the legacy keyboard emulation block.
  assumes ulk_map.svh for the numeric layout.
*/
package ulk_pkg;

  typedef struct packed {
    logic address_gate_state;
    logic mouse_irq_seen;
    logic keyboard_irq_seen;
    logic address_gate_sequence;
    logic external_irq_enable;
    logic legacy_irq_enable;
    logic char_pending;
    logic emulation_irq_flag;
    logic emulation_enable;
  } ulk_ctrl_t;

  typedef struct packed {
    logic parity;
    logic timeout;
    logic aux_out_full;
    logic inhibit_sw;
    logic cmd_data;
    logic flag;
    logic in_full;
    logic out_full;
  } ulk_stat_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } ulk_io_req_t;

endpackage

// File: design/ulk_edge.sv
/*
  per-bit rising edge detector.
  assumes inputs already synchronous to clk_sys.
*/
`timescale 1ns/1ps

module ulk_edge #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] level_in,
  output logic      [WIDTH-1:0] rise
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic prev_q;

      always_ff @(posedge clk_sys)
      begin
        if (!reset_n)
          prev_q <= 1'b0;
        else
          prev_q <= level_in[i];
      end
      assign rise[i] = level_in[i] & ~prev_q;
    end
  endgenerate

endmodule // ulk_edge

// File: design/ulk_emulation.sv
/*
  legacy keyboard and mouse emulation: operational registers, decode of the
  data and command ports, flag side effects and interrupt generation.
  assumes a single-cycle memory register port, single-cycle legacy i/o
  cycles, and keyboard controller interrupt lines synchronous to clk_sys.
*/
`timescale 1ns/1ps
`include "ulk_map.svh"

// Function
// - data port read returns output, clears out-full
// - data port write loads input, sets in-full unless gate repeat
// - command port read returns status, no effect
// - command port write loads input, sets cmd
// - four registers at 100h to 10Ch
// - bit 8 gate state, compared in sequence
// - bit 7 mouse edge, write-1 clears
// - bit 6 keyboard edge, write-1 clears
// - bit 5 set by D1h command
// - external irq enable raises emulation irq
// - legacy irq while out-full, aux selects
// - char pending irq when out-full clears
// - bit 1 read-only emulation irq condition
// - enable bit decodes ports and all but external interrupts
// - memory write loads status, no side effects
// - output register loaded by memory writes
module ulk_emulation #(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic              mem_req,
  input  wire logic              mem_we,
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic [31:0]       mem_wdata,
  output logic      [31:0]       mem_rdata,
  output logic                   mem_ack,
  input  wire logic              io_req,
  input  wire logic              io_we,
  input  wire logic [15:0]       io_addr,
  input  wire logic [7:0]        io_wdata,
  output logic      [7:0]        io_rdata,
  output logic                   io_claim,
  output logic                   io_ack,
  input  wire logic              kbc_keyboard_irq,
  input  wire logic              kbc_mouse_irq,
  output logic                   keyboard_interrupt,
  output logic                   mouse_interrupt,
  output logic                   emulation_irq,
  output logic                   address_gate_state
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration check

  generate
    if (ADDR_W < 12)
    begin : g_bad_addr_w
      $error("ulk_emulation: ADDR_W must be at least 12");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // state

  ulk_pkg::ulk_ctrl_t  ctrl_q;
  ulk_pkg::ulk_ctrl_t  ctrl_d;
  ulk_pkg::ulk_stat_t  stat_q;
  ulk_pkg::ulk_stat_t  stat_d;
  ulk_pkg::ulk_io_req_t io_r;
  logic [7:0]          input_q;
  logic [7:0]          input_d;
  logic [7:0]          output_q;
  logic [7:0]          output_d;
  logic [31:0]         mem_rdata_q;
  logic [31:0]         mem_rdata_d;
  logic                mem_ack_q;
  logic [7:0]          io_rdata_q;
  logic [7:0]          io_rdata_d;
  logic                io_ack_q;

  ////////////////////////////////////////////////////////////////////////////
  // memory register decode

  logic [11:0] mem_off;
  logic        mem_hi_zero;
  logic        sel_ctrl;
  logic        sel_input;
  logic        sel_output;
  logic        sel_status;
  logic        mem_wr;
  logic        wr_ctrl;
  logic        wr_input;
  logic        wr_output;
  logic        wr_status;

  assign mem_off     = mem_addr[11:0];
  assign mem_hi_zero = (mem_addr >> 12) == '0;
  assign sel_ctrl    = mem_hi_zero && (mem_off == `ULK_OFF_CONTROL);
  assign sel_input   = mem_hi_zero && (mem_off == `ULK_OFF_INPUT);
  assign sel_output  = mem_hi_zero && (mem_off == `ULK_OFF_OUTPUT);
  assign sel_status  = mem_hi_zero && (mem_off == `ULK_OFF_STATUS);
  assign mem_wr      = mem_req & mem_we;
  assign wr_ctrl     = mem_wr & sel_ctrl;
  assign wr_input    = mem_wr & sel_input;
  assign wr_output   = mem_wr & sel_output;
  assign wr_status   = mem_wr & sel_status;

  ////////////////////////////////////////////////////////////////////////////
  // legacy i/o decode

  logic io_is_data;
  logic io_is_cmd;
  logic data_rd;
  logic data_wr;
  logic cmd_rd;
  logic cmd_wr;
  logic gate_match;

  assign io_r = {io_req, io_we, io_addr, io_wdata};

  assign io_is_data = io_r.addr == `ULK_PORT_DATA;
  assign io_is_cmd  = io_r.addr == `ULK_PORT_CMD;
  assign io_claim   = ctrl_q.emulation_enable & io_r.req & (io_is_data | io_is_cmd);
  assign data_rd    = io_claim & io_is_data & ~io_r.we;
  assign data_wr    = io_claim & io_is_data & io_r.we;
  assign cmd_rd     = io_claim & io_is_cmd & ~io_r.we;
  assign cmd_wr     = io_claim & io_is_cmd & io_r.we;

  // gate write that repeats the present state raises no request
  assign gate_match = ctrl_q.address_gate_sequence
                    & (io_r.wdata[`ULK_GATE_BIT] == ctrl_q.address_gate_state);

  ////////////////////////////////////////////////////////////////////////////
  // keyboard controller interrupt edges

  logic [1:0] kbc_rise;

  ulk_edge #(
    .WIDTH (2)
  ) u_edge (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .level_in ({kbc_mouse_irq, kbc_keyboard_irq}),
    .rise     (kbc_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // emulation interrupt condition

  logic cond_input;
  logic cond_char;
  logic cond_ext;
  logic emu_cond;

  assign cond_input = ctrl_q.emulation_enable & stat_q.in_full;
  assign cond_char  = ctrl_q.emulation_enable & ctrl_q.char_pending
                    & ~stat_q.out_full;
  assign cond_ext   = ctrl_q.external_irq_enable
                    & (ctrl_q.keyboard_irq_seen | ctrl_q.mouse_irq_seen);
  assign emu_cond   = cond_input | cond_char | cond_ext;

  ////////////////////////////////////////////////////////////////////////////
  // control next value

  always_comb
  begin
    ctrl_d = ctrl_q;
    if (wr_ctrl)
    begin
      ctrl_d.emulation_enable      = mem_wdata[`ULK_CTL_EE];
      ctrl_d.char_pending          = mem_wdata[`ULK_CTL_CP];
      ctrl_d.legacy_irq_enable     = mem_wdata[`ULK_CTL_LEGACY_IRQ_ENABLE];
      ctrl_d.external_irq_enable   = mem_wdata[`ULK_CTL_EXTERNAL_IRQ_ENABLE];
      ctrl_d.address_gate_sequence = mem_wdata[`ULK_CTL_GSEQ];
      ctrl_d.address_gate_state    = mem_wdata[`ULK_CTL_A20];
      if (mem_wdata[`ULK_CTL_KBDA])
        ctrl_d.keyboard_irq_seen = 1'b0;
      if (mem_wdata[`ULK_CTL_MSEA])
        ctrl_d.mouse_irq_seen = 1'b0;
    end
    // edge wins over a same-cycle clear
    if (kbc_rise[0])
      ctrl_d.keyboard_irq_seen = 1'b1;
    if (kbc_rise[1])
      ctrl_d.mouse_irq_seen = 1'b1;
    if (cmd_wr)
      ctrl_d.address_gate_sequence = (io_r.wdata == `ULK_GATE_CMD);
    ctrl_d.emulation_irq_flag = emu_cond;
  end

  ////////////////////////////////////////////////////////////////////////////
  // data registers and status next value

  always_comb
  begin
    stat_d   = stat_q;
    input_d  = input_q;
    output_d = output_q;
    if (wr_input)
      input_d = mem_wdata[7:0];
    if (wr_output)
      output_d = mem_wdata[7:0];
    // plain memory access changes flags only by a status write
    if (wr_status)
      stat_d = mem_wdata[7:0];
    // port side effects override a colliding memory write
    if (data_rd)
      stat_d.out_full = 1'b0;
    if (data_wr)
    begin
      input_d = io_r.wdata;
      stat_d.cmd_data = 1'b0;
      if (!gate_match)
        stat_d.in_full = 1'b1;
    end
    if (cmd_wr)
    begin
      input_d         = io_r.wdata;
      stat_d.in_full  = 1'b0;
      stat_d.cmd_data = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data

  logic [31:0] ctrl_word;

  assign ctrl_word = {23'h000000, ctrl_q[8:2], emu_cond, ctrl_q[0]};

  always_comb
  begin
    mem_rdata_d = 32'h00000000;
    if (sel_ctrl)
      mem_rdata_d = ctrl_word;
    else if (sel_input)
      mem_rdata_d = {24'h000000, input_q};
    else if (sel_output)
      mem_rdata_d = {24'h000000, output_q};
    else if (sel_status)
      mem_rdata_d = {24'h000000, stat_q};
  end

  always_comb
  begin
    io_rdata_d = io_rdata_q;
    if (data_rd)
      io_rdata_d = output_q;
    else if (cmd_rd)
      io_rdata_d = stat_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      ctrl_q   <= `ULK_CTRL_RST;
      stat_q   <= `ULK_BYTE_RST;
      input_q  <= `ULK_BYTE_RST;
      output_q <= `ULK_BYTE_RST;
    end
    else
    begin
      ctrl_q   <= ctrl_d;
      stat_q   <= stat_d;
      input_q  <= input_d;
      output_q <= output_d;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      mem_rdata_q <= 32'h00000000;
      mem_ack_q   <= 1'b0;
      io_rdata_q  <= `ULK_BYTE_RST;
      io_ack_q    <= 1'b0;
    end
    else
    begin
      mem_rdata_q <= (mem_req & ~mem_we) ? mem_rdata_d : mem_rdata_q;
      mem_ack_q   <= mem_req;
      io_rdata_q  <= io_rdata_d;
      io_ack_q    <= io_claim;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  logic legacy_on;

  assign legacy_on          = ctrl_q.emulation_enable & ctrl_q.legacy_irq_enable
                            & stat_q.out_full;
  assign keyboard_interrupt = (legacy_on & ~stat_q.aux_out_full)
                            | ctrl_q.keyboard_irq_seen;
  assign mouse_interrupt    = (legacy_on & stat_q.aux_out_full)
                            | ctrl_q.mouse_irq_seen;
  assign emulation_irq      = ctrl_q.emulation_irq_flag;
  assign address_gate_state = ctrl_q.address_gate_state;
  assign mem_rdata          = mem_rdata_q;
  assign mem_ack            = mem_ack_q;
  assign io_rdata           = io_rdata_q;
  assign io_ack             = io_ack_q;

endmodule // ulk_emulation

// File: sim/ulk_emulation_asserts.sv
/*
  port assertions of the legacy keyboard emulation block.
  assumes ADDR_W of 12 or more; bound to every ulk_emulation.
*/
`timescale 1ns/1ps

module ulk_emulation_asserts #(
  parameter int ADDR_W = 12
) (
  input wire logic              clk_sys,
  input wire logic              reset_n,
  input wire logic              mem_req,
  input wire logic              mem_we,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [31:0]       mem_wdata,
  input wire logic [31:0]       mem_rdata,
  input wire logic              mem_ack,
  input wire logic              io_req,
  input wire logic              io_we,
  input wire logic [15:0]       io_addr,
  input wire logic [7:0]        io_wdata,
  input wire logic [7:0]        io_rdata,
  input wire logic              io_claim,
  input wire logic              io_ack,
  input wire logic              kbc_keyboard_irq,
  input wire logic              kbc_mouse_irq,
  input wire logic              keyboard_interrupt,
  input wire logic              mouse_interrupt,
  input wire logic              emulation_irq,
  input wire logic              address_gate_state
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  logic ctl_wr_q;
  logic quiet_q;
  wire  rd_ctl = mem_req && !mem_we && mem_addr == ADDR_W'(12'h100);

  always_ff @(posedge clk_sys)
  begin
    ctl_wr_q <= reset_n && mem_req && mem_we && mem_addr == ADDR_W'(12'h100);
    quiet_q  <= reset_n && !mem_req && !io_req;
  end

  a_mem_ack_once: assert property (mem_req |=> mem_ack)
    else $error("memory access not acknowledged");
  a_unmapped_zero: assert property ((mem_req && !mem_we && mem_addr > ADDR_W'(12'h10c))
    |=> mem_rdata == 32'h0) else $error("unmapped read not zero");
  a_ctrl_live_bit: assert property (rd_ctl |=> mem_rdata[1] == emulation_irq)
    else $error("control bit 1 differs from emulation irq");
  a_claim_port_only: assert property (io_claim |-> io_req &&
    (io_addr == 16'h0060 || io_addr == 16'h0064)) else $error("claim of foreign port");
  a_io_ack_follow: assert property (io_ack == $past(io_claim))
    else $error("io ack not one cycle after claim");
  a_gate_by_write: assert property ($changed(address_gate_state) |-> ctl_wr_q)
    else $error("gate state moved without control write");
  a_kbd_edge_seen: assert property ($rose(kbc_keyboard_irq) |=> keyboard_interrupt)
    else $error("keyboard edge not seen");
  a_mse_edge_seen: assert property ($rose(kbc_mouse_irq) |=> mouse_interrupt)
    else $error("mouse edge not seen");
  a_kbd_irq_hold: assert property ((keyboard_interrupt && !mem_req && !io_req)
    |=> keyboard_interrupt) else $error("keyboard interrupt dropped alone");
  a_emu_irq_level: assert property ((emulation_irq && quiet_q && !mem_req && !io_req)
    |=> emulation_irq) else $error("emulation irq dropped alone");
endmodule // ulk_emulation_asserts

bind ulk_emulation ulk_emulation_asserts #(.ADDR_W(ADDR_W)) u_chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .mem_req(mem_req), .mem_we(mem_we),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
  .io_req(io_req), .io_we(io_we), .io_addr(io_addr), .io_wdata(io_wdata),
  .io_rdata(io_rdata), .io_claim(io_claim), .io_ack(io_ack),
  .kbc_keyboard_irq(kbc_keyboard_irq), .kbc_mouse_irq(kbc_mouse_irq),
  .keyboard_interrupt(keyboard_interrupt), .mouse_interrupt(mouse_interrupt),
  .emulation_irq(emulation_irq), .address_gate_state(address_gate_state));

// File: sim/ulk_kbc_model.sv
/*
  keyboard controller stand-in driving its two interrupt lines.
  assumes go pulses from the bench, synchronous to clk_sys.
*/
`timescale 1ns/1ps

module ulk_kbc_model (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic kbd_go,
  input  wire logic mse_go,
  output logic      kbc_keyboard_irq,
  output logic      kbc_mouse_irq
);
  logic [1:0] kbd_q;
  logic [1:0] mse_q;

  // each go gives one rising edge, line held three cycles
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      kbd_q <= 2'h0;
      mse_q <= 2'h0;
    end
    else
    begin
      kbd_q <= kbd_go ? 2'h3 : kbd_q - {1'b0, kbd_q != 2'h0};
      mse_q <= mse_go ? 2'h3 : mse_q - {1'b0, mse_q != 2'h0};
    end
  end

  assign kbc_keyboard_irq = (kbd_q != 2'h0);
  assign kbc_mouse_irq    = (mse_q != 2'h0);
endmodule // ulk_kbc_model

// File: sim/tb.sv
/*
  self-checking bench of the legacy keyboard emulation block.
  assumes ulk_map.svh offsets and the keyboard controller model.
*/
`timescale 1ns/1ps
`include "ulk_map.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module tb;
  logic        clk_sys, reset_n, mem_req, mem_we, io_req, io_we, kbd_go, mse_go;
  logic        mem_ack, io_claim, io_ack, kbc_keyboard_irq, kbc_mouse_irq;
  logic        keyboard_interrupt, mouse_interrupt, emulation_irq, address_gate_state;
  logic [11:0] mem_addr;
  logic [31:0] mem_wdata, mem_rdata;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, b;
  int          err_total, n_tests, cycles;

  ulk_emulation uut (.clk_sys, .reset_n, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_rdata, .mem_ack, .io_req, .io_we, .io_addr, .io_wdata, .io_rdata, .io_claim,
    .io_ack, .kbc_keyboard_irq, .kbc_mouse_irq, .keyboard_interrupt, .mouse_interrupt,
    .emulation_irq, .address_gate_state);
  ulk_kbc_model u_kbc (.clk_sys, .reset_n, .kbd_go, .mse_go, .kbc_keyboard_irq,
    .kbc_mouse_irq);

  initial
  begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic mem_op(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q);
    mem_req = 1; mem_we = w; mem_addr = a; mem_wdata = d;
    @(posedge clk_sys); #1;
    mem_req = 0;
    `CHK("mem_ack", 1'b1, mem_ack)
    q = mem_rdata;
    // idle cycle so the next request is not raised in the same step
    @(posedge clk_sys); #1;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    mem_op(1, a, d, q);
  endtask

  task automatic chk_reg(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    mem_op(0, a, 32'h0, q);
    `CHK($sformatf("reg %h", a), e, q)
  endtask

  task automatic io_op(input logic w, input logic [15:0] a, input logic [7:0] d,
                       input logic c);
    io_req = 1; io_we = w; io_addr = a; io_wdata = d;
    #1;
    `CHK("io_claim", c, io_claim)
    @(posedge clk_sys); #1;
    io_req = 0;
    `CHK("io_ack", c, io_ack)
    b = io_rdata;
    // idle cycle so the next request is not raised in the same step
    @(posedge clk_sys); #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk_reg(`ULK_OFF_CONTROL, 32'h0);
    wr(12'h110, 32'hffffffff);
    chk_reg(12'h110, 32'h0);
    `CHK("emulation_irq", 1'b0, emulation_irq)
    $display("test reset done");
  endtask

  task automatic t_ports;
    wr(`ULK_OFF_CONTROL, 32'h1);
    wr(`ULK_OFF_OUTPUT, 32'ha5);
    wr(`ULK_OFF_STATUS, 32'h01);
    io_op(0, `ULK_PORT_DATA, 8'h00, 1);
    `CHK("in data", 8'ha5, b)
    chk_reg(`ULK_OFF_STATUS, 32'h00);
    wr(`ULK_OFF_STATUS, 32'h21);
    io_op(0, `ULK_PORT_CMD, 8'h00, 1);
    `CHK("in status", 8'h21, b)
    chk_reg(`ULK_OFF_STATUS, 32'h21);
    io_op(1, `ULK_PORT_DATA, 8'h3c, 1);
    chk_reg(`ULK_OFF_INPUT, 32'h3c);
    chk_reg(`ULK_OFF_STATUS, 32'h23);
    io_op(1, `ULK_PORT_CMD, `ULK_GATE_CMD, 1);
    chk_reg(`ULK_OFF_INPUT, 32'hd1);
    chk_reg(`ULK_OFF_STATUS, 32'h29);
    chk_reg(`ULK_OFF_CONTROL, 32'h21);
    io_op(1, `ULK_PORT_DATA, 8'h00, 1);
    chk_reg(`ULK_OFF_STATUS, 32'h21);
    wr(`ULK_OFF_CONTROL, 32'h121);
    `CHK("gate", 1'b1, address_gate_state)
    io_op(1, `ULK_PORT_DATA, 8'h00, 1);
    chk_reg(`ULK_OFF_STATUS, 32'h23);
    io_op(1, `ULK_PORT_CMD, 8'h20, 1);
    chk_reg(`ULK_OFF_CONTROL, 32'h101);
    io_op(1, 16'h0061, 8'h55, 0);
    wr(`ULK_OFF_CONTROL, 32'h0);
    io_op(1, `ULK_PORT_DATA, 8'h77, 0);
    io_op(0, `ULK_PORT_CMD, 8'h00, 0);
    chk_reg(`ULK_OFF_INPUT, 32'h20);
    $display("test ports done");
  endtask

  task automatic t_legacy;
    wr(`ULK_OFF_CONTROL, 32'h09);
    wr(`ULK_OFF_STATUS, 32'h01);
    `CHK("kbd int", 1'b1, keyboard_interrupt)
    `CHK("mse int", 1'b0, mouse_interrupt)
    wr(`ULK_OFF_STATUS, 32'h21);
    `CHK("mse int", 1'b1, mouse_interrupt)
    io_op(0, `ULK_PORT_DATA, 8'h00, 1);
    `CHK("mse int", 1'b0, mouse_interrupt)
    wr(`ULK_OFF_STATUS, 32'h01);
    wr(`ULK_OFF_CONTROL, 32'h05);
    `CHK("kbd int", 1'b0, keyboard_interrupt)
    `CHK("emulation_irq", 1'b0, emulation_irq)
    io_op(0, `ULK_PORT_DATA, 8'h00, 1);
    @(posedge clk_sys); #1;
    `CHK("emulation_irq", 1'b1, emulation_irq)
    wr(`ULK_OFF_CONTROL, 32'h03);
    chk_reg(`ULK_OFF_CONTROL, 32'h01);
    `CHK("emulation_irq", 1'b0, emulation_irq)
    $display("test legacy done");
  endtask

  task automatic t_external;
    logic [31:0] m;
    for (int i = 0; i < 2; i++)
    begin
      m = (i == 0) ? 32'h40 : 32'h80;
      wr(`ULK_OFF_CONTROL, 32'h10);
      kbd_go = (i == 0);
      mse_go = (i == 1);
      @(posedge clk_sys); #1;
      kbd_go = 0;
      mse_go = 0;
      repeat (3) @(posedge clk_sys);
      #1;
      `CHK("emulation_irq", 1'b1, emulation_irq)
      `CHK("line", 1'b1, i ? mouse_interrupt : keyboard_interrupt)
      wr(`ULK_OFF_CONTROL, 32'h10);
      chk_reg(`ULK_OFF_CONTROL, 32'h12 | m);
      wr(`ULK_OFF_CONTROL, 32'h10 | m);
      chk_reg(`ULK_OFF_CONTROL, 32'h10);
      `CHK("line", 1'b0, i ? mouse_interrupt : keyboard_interrupt)
    end
    $display("test external done");
  endtask

  initial
  begin
    reset_n = 0; mem_req = 0; mem_we = 0; mem_addr = 0; mem_wdata = 0;
    io_req = 0; io_we = 0; io_addr = 0; io_wdata = 0; kbd_go = 0; mse_go = 0;
    err_total = 0; n_tests = 0; cycles = 0;
    repeat (6) @(posedge clk_sys);
    #1;
    reset_n = 1;
    t_reset();
    t_ports();
    t_legacy();
    t_external();
    finish_test();
  end
endmodule // tb
